// *** rtl/pwmoe_consts.vh ***
// Register map, field positions, reset values and fixed bits of the PWM output control block.
`ifndef PWMOE_CONSTS_VH
`define PWMOE_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define PWMOE_ADDR_MASTER_EN   12'h000
`define PWMOE_ADDR_OUT_CTRL    12'h004
`define PWMOE_ADDR_WIDTH       12

// ----------------------------------------------------------------------------
// Master-enable fields
// ----------------------------------------------------------------------------
`define PWMOE_ME_GATE_LSB      0
`define PWMOE_ME_GATE_MSB      5
`define PWMOE_ME_GATE_RESET    6'h00
`define PWMOE_ME_FIXED_ONES    2'h3

// ----------------------------------------------------------------------------
// Output-control fields
// ----------------------------------------------------------------------------
`define PWMOE_OC_POS_LVL_BIT   0
`define PWMOE_OC_REV_LVL_BIT   1
`define PWMOE_OC_TOGGLE_BIT    6
`define PWMOE_OC_TOGGLE_RESET  1'h0
`define PWMOE_OC_POS_RESET     1'h0
`define PWMOE_OC_REV_RESET     1'h0

// ----------------------------------------------------------------------------
// Pin index layout inside the six-bit gate field
// ----------------------------------------------------------------------------
`define PWMOE_PHASES           3
`define PWMOE_REV_BASE         3
`define PWMOE_BUS_LATENCY      1

`endif

// *** rtl/pwmoe_phase.v ***
// One phase of the count-start-synchronized and complementary PWM level logic.
`timescale 1ns/1ns

module pwmoe_phase (
    input  wire pclk,
    input  wire presetn,
    input  wire clk_en,
    input  wire count_start,
    input  wire dead_time_done,
    input  wire up_match,
    input  wire down_match,
    input  wire positive_level_select,
    input  wire reverse_level_select,
    output reg  pos_level,
    output reg  rev_level
);

    reg rev_hold;

    // ------------------------------------------------------------------------
    // Positive-phase level
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_level <= 1'b1;
        end else if (clk_en) begin
            if (count_start) begin
                pos_level <= ~positive_level_select;
            end else if (up_match) begin
                pos_level <= positive_level_select;
            end else if (down_match) begin
                pos_level <= ~positive_level_select;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Reverse-phase level with dead-time hold
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rev_level <= 1'b1;
            rev_hold  <= 1'b0;
        end else if (clk_en) begin
            if (count_start) begin
                rev_level <= ~reverse_level_select;
                rev_hold  <= 1'b1;
            end else if (rev_hold) begin
                if (dead_time_done) begin
                    rev_level <= reverse_level_select;
                    rev_hold  <= 1'b0;
                end
            end else if (up_match) begin
                rev_level <= ~reverse_level_select;
            end else if (down_match) begin
                rev_level <= reverse_level_select;
            end
        end
    end

endmodule

// *** rtl/pwmoe_top.v ***
// APB-controlled output gating and level selection for six three-phase PWM pins.
`timescale 1ns/1ns
`include "pwmoe_consts.vh"

module pwmoe_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    input  wire        pwm_mode,
    input  wire        count_start,
    input  wire        dead_time_done,
    input  wire        period_pulse,
    input  wire [2:0]  up_match,
    input  wire [2:0]  down_match,
    input  wire [5:0]  timer_wave,
    output wire        u_positive_pin,
    output wire        v_positive_pin,
    output wire        w_positive_pin,
    output wire        u_reverse_pin,
    output wire        v_reverse_pin,
    output wire        w_reverse_pin,
    output wire        u_positive_pin_oe,
    output wire        v_positive_pin_oe,
    output wire        w_positive_pin_oe,
    output wire        u_reverse_pin_oe,
    output wire        v_reverse_pin_oe,
    output wire        w_reverse_pin_oe,
    output wire        period_toggle_out
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    reg  [5:0]  gate;
    reg         period_toggle_enable;
    reg         reverse_level_select;
    reg         positive_level_select;
    reg         ready_q;
    reg         slverr_q;
    reg  [31:0] rdata_q;
    wire [5:0]  pin_level;
    wire [5:0]  pin_drive;
    reg         toggle_q;
    reg  [31:0] next_rdata;
    reg         next_slverr;
    wire [2:0]  pos_level;
    wire [2:0]  rev_level;
    wire        access;
    wire        wr_done;
    wire        pwm_start;
    wire        pwm_dead;
    wire [2:0]  pwm_up;
    wire [2:0]  pwm_down;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    function reg_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            reg_hit = (addr[11:2] == offset[11:2]);
        end
    endfunction

    function mapped;
        input [11:0] addr;
        begin
            mapped = reg_hit(addr, `PWMOE_ADDR_MASTER_EN) |
                     reg_hit(addr, `PWMOE_ADDR_OUT_CTRL);
        end
    endfunction

    // ------------------------------------------------------------------------
    // APB slave handshake
    // ------------------------------------------------------------------------
    assign access  = psel & penable & ~ready_q;
    assign wr_done = psel & penable & ready_q & pwrite & ~slverr_q;

    always @* begin
        next_rdata  = 32'h0000_0000;
        next_slverr = ~mapped(paddr);
        if (!pwrite) begin
            if (reg_hit(paddr, `PWMOE_ADDR_MASTER_EN)) begin
                next_rdata[7:6] = `PWMOE_ME_FIXED_ONES;
                next_rdata[`PWMOE_ME_GATE_MSB:`PWMOE_ME_GATE_LSB] = gate;
            end else if (reg_hit(paddr, `PWMOE_ADDR_OUT_CTRL)) begin
                next_rdata[`PWMOE_OC_TOGGLE_BIT]  = period_toggle_enable;
                next_rdata[`PWMOE_OC_REV_LVL_BIT] = reverse_level_select;
                next_rdata[`PWMOE_OC_POS_LVL_BIT] = positive_level_select;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q  <= 1'b0;
            slverr_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            ready_q  <= access;
            if (access) begin
                slverr_q <= next_slverr;
                rdata_q  <= next_rdata;
            end else begin
                slverr_q <= 1'b0;
                rdata_q  <= 32'h0000_0000;
            end
        end
    end

    assign pready  = ready_q;
    assign prdata  = rdata_q;
    assign pslverr = slverr_q;

    // ------------------------------------------------------------------------
    // Master-enable register
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= `PWMOE_ME_GATE_RESET;
        end else if (clk_en) begin
            if (wr_done && pstrb[0] && reg_hit(paddr, `PWMOE_ADDR_MASTER_EN)) begin
                gate <= pwdata[`PWMOE_ME_GATE_MSB:`PWMOE_ME_GATE_LSB];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Output-control register
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_toggle_enable  <= `PWMOE_OC_TOGGLE_RESET;
            reverse_level_select  <= `PWMOE_OC_REV_RESET;
            positive_level_select <= `PWMOE_OC_POS_RESET;
        end else if (clk_en) begin
            if (wr_done && pstrb[0] && reg_hit(paddr, `PWMOE_ADDR_OUT_CTRL)) begin
                period_toggle_enable  <= pwdata[`PWMOE_OC_TOGGLE_BIT];
                reverse_level_select  <= pwdata[`PWMOE_OC_REV_LVL_BIT];
                positive_level_select <= pwdata[`PWMOE_OC_POS_LVL_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // PWM-mode qualified timer events
    // ------------------------------------------------------------------------
    assign pwm_start = pwm_mode & count_start;
    assign pwm_dead  = pwm_mode & dead_time_done;
    assign pwm_up    = pwm_mode ? up_match : 3'h0;
    assign pwm_down  = pwm_mode ? down_match : 3'h0;

    genvar ph;
    generate
        for (ph = 0; ph < `PWMOE_PHASES; ph = ph + 1) begin : g_phase
            pwmoe_phase u_phase (
                .pclk                  (pclk),
                .presetn               (presetn),
                .clk_en                (clk_en),
                .count_start           (pwm_start),
                .dead_time_done        (pwm_dead),
                .up_match              (pwm_up[ph]),
                .down_match            (pwm_down[ph]),
                .positive_level_select (positive_level_select),
                .reverse_level_select  (reverse_level_select),
                .pos_level             (pos_level[ph]),
                .rev_level             (rev_level[ph])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Pin gating
    // ------------------------------------------------------------------------
    genvar pn;
    generate
        for (pn = 0; pn < 6; pn = pn + 1) begin : g_pin
            reg lvl_q;
            reg drv_q;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lvl_q <= 1'b0;
                    drv_q <= 1'b0;
                end else if (clk_en) begin
                    drv_q <= gate[pn];
                    if (!gate[pn]) begin
                        lvl_q <= 1'b0;
                    end else if (!pwm_mode) begin
                        lvl_q <= timer_wave[pn];
                    end else if (pn < `PWMOE_REV_BASE) begin
                        lvl_q <= pos_level[pn % `PWMOE_PHASES];
                    end else begin
                        lvl_q <= rev_level[pn % `PWMOE_PHASES];
                    end
                end
            end
            assign pin_level[pn] = lvl_q;
            assign pin_drive[pn] = drv_q;
        end
    endgenerate

    assign u_positive_pin    = pin_level[0];
    assign v_positive_pin    = pin_level[1];
    assign w_positive_pin    = pin_level[2];
    assign u_reverse_pin     = pin_level[3];
    assign v_reverse_pin     = pin_level[4];
    assign w_reverse_pin     = pin_level[5];
    assign u_positive_pin_oe = pin_drive[0];
    assign v_positive_pin_oe = pin_drive[1];
    assign w_positive_pin_oe = pin_drive[2];
    assign u_reverse_pin_oe  = pin_drive[3];
    assign v_reverse_pin_oe  = pin_drive[4];
    assign w_reverse_pin_oe  = pin_drive[5];

    // ------------------------------------------------------------------------
    // Period-synchronized toggle output
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_q <= 1'b0;
        end else if (clk_en) begin
            if (period_toggle_enable && pwm_mode && period_pulse) begin
                toggle_q <= ~toggle_q;
            end
        end
    end

    assign period_toggle_out = toggle_q;

endmodule

// *** verification/pwmoe_gate_stage.sv ***
// Gate drive stage model for the six PWM pins.
`timescale 1ns/1ns
module pwmoe_gate_stage (
    input  wire [5:0] pin,
    input  wire [5:0] oe,
    output wire [5:0] drive
);
    // Gate inputs have pull-downs, so a pin left undriven reads low.
    assign drive = oe & pin;
endmodule

// *** verification/pwmoe_checker.sv ***
// Concurrent checks on the ports of the PWM output block.
`timescale 1ns/1ns
module pwmoe_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        clk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        pwm_mode,
    input wire        count_start,
    input wire        dead_time_done,
    input wire        period_pulse,
    input wire [2:0]  up_match,
    input wire [2:0]  down_match,
    input wire [5:0]  timer_wave,
    input wire        u_positive_pin,
    input wire        w_reverse_pin,
    input wire        u_positive_pin_oe,
    input wire        w_reverse_pin_oe,
    input wire        period_toggle_out
);
    // ------------------------------------------------------------------------
    // Shadow of the level selects and the dead-time state
    // ------------------------------------------------------------------------
    reg  pos_sel;
    reg  rev_sel;
    reg  dead_q;
    wire ok    = clk_en & pwm_mode;
    wire acc   = psel & penable & pready & clk_en;
    wire quiet = ok & ~count_start & ~dead_time_done & ~(|up_match) & ~(|down_match);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_sel <= 1'b0;
            rev_sel <= 1'b0;
            dead_q <= 1'b0;
        end else begin
            if (acc & pwrite & pstrb[0] & ~pslverr & paddr[11:2] == 10'h001) begin
                pos_sel <= pwdata[0];
                rev_sel <= pwdata[1];
            end
            if (ok & count_start)
                dead_q <= 1'b0;
            else if (ok & dead_time_done)
                dead_q <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_me_fixed_ones: assert property (
        acc & ~pwrite & paddr[11:2] == 10'h000 |-> prdata[31:6] == 26'h3)
        else $error("Master enable fixed bits wrong.");
    chk_oc_zero_bits: assert property (
        acc & ~pwrite & paddr[11:2] == 10'h001 |-> prdata[31:7] == 25'h0 && prdata[5:2] == 4'h0)
        else $error("Output control reserved bits wrong.");
    chk_gate_off_pin: assert property (
        (!u_positive_pin_oe |-> !u_positive_pin) and (!w_reverse_pin_oe |-> !w_reverse_pin))
        else $error("Gated pin carries output.");
    chk_oe_follows_gate: assert property (
        acc & pwrite & pstrb[0] & paddr[11:2] == 10'h000 |-> ##2
        {w_reverse_pin_oe, u_positive_pin_oe} == {$past(pwdata[5], 2), $past(pwdata[0], 2)})
        else $error("Pin enable does not follow gate bit.");
    chk_answer_wait: assert property (
        psel & penable & ~pready & clk_en & ~$past(penable) |=> pready)
        else $error("Bus answer late.");
    chk_toggle_cause: assert property (
        $changed(period_toggle_out) |-> $past(period_pulse & pwm_mode & clk_en))
        else $error("Toggle output changed without period pulse.");
    chk_wave_follow: assert property (
        ~pwm_mode & u_positive_pin_oe & $past(~pwm_mode & u_positive_pin_oe)
        |-> u_positive_pin == $past(timer_wave[0]))
        else $error("Pin does not follow timer wave.");
    chk_pos_up_match: assert property (
        ok & up_match[0] & ~down_match[0] & ~count_start ##1 quiet & u_positive_pin_oe
        |=> u_positive_pin == pos_sel)
        else $error("Positive level after up match wrong.");
    chk_rev_down_match: assert property (
        ok & dead_q & down_match[2] & ~up_match[2] & ~count_start ##1 quiet & w_reverse_pin_oe
        |=> w_reverse_pin == rev_sel)
        else $error("Reverse level after down match wrong.");
    chk_start_level: assert property (
        ok & count_start ##1 quiet & u_positive_pin_oe & w_reverse_pin_oe
        |=> u_positive_pin == !pos_sel && w_reverse_pin == !rev_sel)
        else $error("Initial levels after count start wrong.");
endmodule
bind pwmoe_top pwmoe_checker chk_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_mode(pwm_mode),
    .count_start(count_start), .dead_time_done(dead_time_done), .period_pulse(period_pulse),
    .up_match(up_match), .down_match(down_match), .timer_wave(timer_wave),
    .u_positive_pin(u_positive_pin), .w_reverse_pin(w_reverse_pin),
    .u_positive_pin_oe(u_positive_pin_oe), .w_reverse_pin_oe(w_reverse_pin_oe),
    .period_toggle_out(period_toggle_out));

// *** verification/tb_pwm_output_enable_level_control.sv ***
// Self-checking testbench of the PWM output gating and level block.
`timescale 1ns/1ns
`include "pwmoe_consts.vh"
module tb_pwm_output_enable_level_control;
    // ------------------------------------------------------------------------
    // Stimulus, design and gate stage
    // ------------------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic        pwm_mode = 1'b0;
    logic        clk_en = 1'b1;
    logic [8:0]  ev_v = 9'h000;
    logic [5:0]  timer_wave = 6'h00;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [5:0]  g;
    logic [5:0]  w;
    logic        r, p, en, tog;
    wire         pready, pslverr, tog_out;
    wire  [31:0] prdata;
    wire  [5:0]  pin, oe, drv;
    integer      fail_count = 0;
    integer      num_checks = 0;
    integer      seed = 15342;
    integer      i;
    always #5 pclk = ~pclk;
    pwmoe_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_mode(pwm_mode),
        .count_start(ev_v[8]), .dead_time_done(ev_v[7]), .period_pulse(ev_v[6]),
        .up_match(ev_v[5:3]), .down_match(ev_v[2:0]), .timer_wave(timer_wave),
        .u_positive_pin(pin[0]), .v_positive_pin(pin[1]), .w_positive_pin(pin[2]),
        .u_reverse_pin(pin[3]), .v_reverse_pin(pin[4]), .w_reverse_pin(pin[5]),
        .u_positive_pin_oe(oe[0]), .v_positive_pin_oe(oe[1]), .w_positive_pin_oe(oe[2]),
        .u_reverse_pin_oe(oe[3]), .v_reverse_pin_oe(oe[4]), .w_reverse_pin_oe(oe[5]),
        .period_toggle_out(tog_out));
    pwmoe_gate_stage gate_u (.pin(pin), .oe(oe), .drive(drv));
    task check(input string nm, input logic [32:0] seen, input logic [32:0] want);
        begin
            num_checks = num_checks + 1;
            if (seen !== want) begin
                fail_count = fail_count + 1;
                $display("BAD %s expected %h seen %h", nm, want, seen);
            end
        end
    endtask
    task stop_test;
        begin
            check("read queue", 33'(exp_q.size()), 33'h0);
            $display("checks %0d mismatches %0d", num_checks, fail_count);
            if (fail_count == 0 && num_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
        begin
            if (!wr)
                exp_q.push_back(x);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do begin
                @(posedge pclk);
            end while (pready !== 1'b1);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task ev(input logic [8:0] v);
        begin
            ev_v <= v;
            @(posedge pclk);
            ev_v <= 9'h000;
            repeat (3) @(posedge pclk);
        end
    endtask
    task pins_chk(input string nm, input logic [5:0] want);
        check(nm, 33'(drv), 33'(want));
    endtask
    always @(negedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            e = exp_q.size() ? exp_q.pop_front() : 33'h1FFFFFFFF;
            check("read", {pslverr, prdata}, e);
        end
    end
    initial begin
        #20000;
        fail_count = fail_count + 1;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("after reset", 33'({oe, drv, tog_out}), 33'h0);
        apb(1'b0, `PWMOE_ADDR_MASTER_EN, 32'h0, 33'h0C0);
        apb(1'b0, `PWMOE_ADDR_OUT_CTRL, 32'h0, 33'h0);
        apb(1'b0, 12'h008, 32'h0, 33'h100000000);
        for (i = 0; i < 8; i = i + 1) begin
            g = $random(seed);
            w = $random(seed);
            timer_wave <= w;
            apb(1'b1, `PWMOE_ADDR_MASTER_EN, 32'({2'b11, g}), 33'h0);
            apb(1'b0, `PWMOE_ADDR_MASTER_EN, 32'h0, 33'({2'b11, g}));
            check("gates", 33'(oe), 33'(g));
            pins_chk("wave", w & g);
        end
        apb(1'b1, `PWMOE_ADDR_OUT_CTRL, 32'hFF, 33'h0);
        apb(1'b0, `PWMOE_ADDR_OUT_CTRL, 32'h0, 33'h043);
        apb(1'b1, `PWMOE_ADDR_MASTER_EN, 32'hFF, 33'h0);
        pwm_mode <= 1'b1;
        tog = tog_out;
        for (i = 0; i < 4; i = i + 1) begin
            {r, p} = i[1:0];
            en = ~i[0];
            apb(1'b1, `PWMOE_ADDR_OUT_CTRL, 32'({en, 4'h0, r, p}), 33'h0);
            apb(1'b0, `PWMOE_ADDR_OUT_CTRL, 32'h0, 33'({en, 4'h0, r, p}));
            ev(9'h100);
            pins_chk("start", {{3{~r}}, {3{~p}}});
            ev(9'h038);
            pins_chk("up before dead", {{3{~r}}, {3{p}}});
            ev(9'h080);
            pins_chk("dead done", {{3{r}}, {3{p}}});
            ev(9'h038);
            pins_chk("up", {{3{~r}}, {3{p}}});
            ev(9'h007);
            pins_chk("down", {{3{r}}, {3{~p}}});
            ev(9'h040);
            tog = tog ^ en;
            check("toggle", 33'(tog_out), 33'(tog));
        end
        clk_en <= 1'b0;
        ev(9'h1FF);
        clk_en <= 1'b1;
        pins_chk("frozen", {{3{r}}, {3{~p}}});
        check("frozen toggle", 33'(tog_out), 33'(tog));
        pwm_mode <= 1'b0;
        timer_wave <= w;
        ev(9'h040);
        check("toggle off mode", 33'(tog_out), 33'(tog));
        pins_chk("wave off mode", w);
        pstrb <= 4'hE;
        apb(1'b1, `PWMOE_ADDR_MASTER_EN, 32'hC0, 33'h0);
        pstrb <= 4'hF;
        apb(1'b0, `PWMOE_ADDR_MASTER_EN, 32'h0, 33'h0FF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset again", 33'({oe, drv, tog_out}), 33'h0);
        apb(1'b0, `PWMOE_ADDR_MASTER_EN, 32'h0, 33'h0C0);
        apb(1'b0, `PWMOE_ADDR_OUT_CTRL, 32'h0, 33'h0);
        stop_test;
    end
endmodule
